//--- rtl/pas_top.sv
// Purpose: PWM auto-shutdown with restart control and half-bridge dead band.
// Assumes: Period strobe and raw pair levels come from the PWM generator.
// Notes: Pins are forced combinationally from the raw condition inputs.
//
// Local design decisions: the address map and strobed register access.
`include "pas_defines.svh"
`default_nettype none
module pas_top
    import pas_pkg::*;
#(
    parameter int DB_W = 7
) (
    input wire logic clk, // Instruction clock, 25 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic [`PAS_ADDR_W-1:0] addr, // Register index
    input wire logic [7:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [7:0] rdata, // Read data, cycle after rd
    input wire logic comparator_one, // Comparator one output, async
    input wire logic comparator_two, // Comparator two output, async
    input wire logic int_pin_n, // External interrupt pin, async
    input wire logic period_start, // One-cycle strobe at PWM period start
    input wire logic raw_ac, // Raw active-high PWM for pair A/C
    input wire logic raw_bd, // Raw active-high PWM for pair B/D
    output logic out_a, // Pin A level
    output logic out_a_oe, // Pin A drive enable
    output logic out_b, // Pin B level
    output logic out_b_oe, // Pin B drive enable
    output logic out_c, // Pin C level
    output logic out_c_oe, // Pin C drive enable
    output logic out_d, // Pin D level
    output logic out_d_oe, // Pin D drive enable
    output logic shutdown_active, // Outputs in shutdown state
    output logic irq // Level interrupt
);
    initial begin
        if (DB_W != `PAS_DB_HI - `PAS_DB_LO + 1) $error("DB_W must match field width");
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic shutdown_event_flag_r;
    pas_src_type shutdown_source_select_r;
    logic [1:0] pair_ac_shutdown_state_r;
    logic [1:0] pair_bd_shutdown_state_r;
    logic auto_restart_enable_r;
    logic [DB_W-1:0] dead_band_count_r;
    logic half_bridge_r;
    logic pol_ac_low_r;
    logic pol_bd_low_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic [7:0] rdata_r;
    pas_state_type state_r;
    pas_state_type state_nxt;

    logic cmp1_s;
    logic cmp2_s;
    logic pin_n_s;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    pas_sync #(.W(3), .INIT(3'b100)) u_sync (
        .clk(clk),
        .rst(rst),
        .d({int_pin_n, comparator_two, comparator_one}),
        .q({pin_n_s, cmp2_s, cmp1_s})
    );

    // ----------------------------------------------------------------
    // Source selection
    // ----------------------------------------------------------------
    function automatic logic sel_cond(input pas_src_type sel, input logic c1,
                                      input logic c2, input logic pin_n);
        logic r;
        r = 1'b0;
        unique case (sel)
            PAS_SRC_OFF: r = 1'b0;
            PAS_SRC_CMP1: r = c1;
            PAS_SRC_CMP2: r = c2;
            PAS_SRC_CMPX: r = c1 | c2;
            PAS_SRC_PIN: r = !pin_n;
            PAS_SRC_PIN_C1: r = !pin_n | c1;
            PAS_SRC_PIN_C2: r = !pin_n | c2;
            PAS_SRC_ALL: r = !pin_n | c1 | c2;
        endcase
        return r;
    endfunction

    // Level condition, not an edge; synced copy drives the flag
    logic cond_s;
    logic cond_async;
    assign cond_s = sel_cond(shutdown_source_select_r, cmp1_s, cmp2_s, pin_n_s);
    // Unsynced copy forces pins without waiting for a clock edge
    assign cond_async = sel_cond(shutdown_source_select_r, comparator_one, comparator_two,
                                 int_pin_n);

    logic wr_shdn;
    logic wr_flag_one;
    logic wr_flag_zero;
    assign wr_shdn = wr && (addr == `PAS_REG_SHDN);
    assign wr_flag_one = wr_shdn && wdata[`PAS_SHDN_FLAG_BIT];
    assign wr_flag_zero = wr_shdn && !wdata[`PAS_SHDN_FLAG_BIT];

    // ----------------------------------------------------------------
    // Shutdown status flag
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            shutdown_event_flag_r <= 1'b0;
        end else if (cond_s || wr_flag_one) begin
            shutdown_event_flag_r <= 1'b1;
        end else if (auto_restart_enable_r) begin
            shutdown_event_flag_r <= 1'b0;
        end else if (wr_flag_zero) begin
            // Clear only reaches here with no condition present
            shutdown_event_flag_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Output state sequence
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PAS_RUN: begin
                if (cond_s || wr_flag_one) state_nxt = PAS_SHUT;
            end
            PAS_SHUT: begin
                if (!shutdown_event_flag_r) state_nxt = PAS_WAIT;
            end
            PAS_WAIT: begin
                if (shutdown_event_flag_r) state_nxt = PAS_SHUT;
                else if (period_start) state_nxt = PAS_RUN;
            end
            default: state_nxt = PAS_SHUT;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= PAS_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    logic shut;
    assign shut = (state_r != PAS_RUN) || cond_async;
    assign shutdown_active = shut;

    // ----------------------------------------------------------------
    // Dead band, half-bridge only
    // ----------------------------------------------------------------
    logic ac_act;
    logic bd_act;
    pas_deadband #(.CNT_W(DB_W)) u_db_ac (
        .clk(clk),
        .rst(rst),
        .enable(half_bridge_r),
        .delay(dead_band_count_r),
        .raw(raw_ac),
        .dly(ac_act)
    );
    pas_deadband #(.CNT_W(DB_W)) u_db_bd (
        .clk(clk),
        .rst(rst),
        .enable(half_bridge_r),
        .delay(dead_band_count_r),
        .raw(raw_bd),
        .dly(bd_act)
    );

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    logic lvl_ac;
    logic lvl_bd;
    logic oe_ac;
    logic oe_bd;
    always_comb begin
        if (shut) begin
            lvl_ac = pair_ac_shutdown_state_r == 2'b01;
            lvl_bd = pair_bd_shutdown_state_r == 2'b01;
            oe_ac = !pair_ac_shutdown_state_r[1];
            oe_bd = !pair_bd_shutdown_state_r[1];
        end else begin
            lvl_ac = ac_act ^ pol_ac_low_r;
            lvl_bd = bd_act ^ pol_bd_low_r;
            oe_ac = 1'b1;
            oe_bd = 1'b1;
        end
    end
    // Pair A/C shares one field; C copies A and D copies B in every mode
    assign out_a = lvl_ac;
    assign out_c = lvl_ac;
    assign out_b = lvl_bd;
    assign out_d = lvl_bd;
    assign out_a_oe = oe_ac;
    assign out_c_oe = oe_ac;
    assign out_b_oe = oe_bd;
    assign out_d_oe = oe_bd;

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            shutdown_source_select_r <= PAS_SRC_OFF;
            pair_ac_shutdown_state_r <= 2'b00;
            pair_bd_shutdown_state_r <= 2'b00;
        end else if (wr_shdn) begin
            shutdown_source_select_r <= pas_src_type'(wdata[`PAS_SRC_HI:`PAS_SRC_LO]);
            pair_ac_shutdown_state_r <= wdata[`PAS_AC_HI:`PAS_AC_LO];
            pair_bd_shutdown_state_r <= wdata[`PAS_BD_HI:`PAS_BD_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            auto_restart_enable_r <= 1'b0;
            dead_band_count_r <= '0;
        end else if (wr && addr == `PAS_REG_PWMCON) begin
            auto_restart_enable_r <= wdata[`PAS_RESTART_BIT];
            dead_band_count_r <= wdata[`PAS_DB_HI:`PAS_DB_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            half_bridge_r <= 1'b0;
            pol_ac_low_r <= 1'b0;
            pol_bd_low_r <= 1'b0;
        end else if (wr && addr == `PAS_REG_MODE) begin
            half_bridge_r <= wdata[`PAS_MODE_HALF_BIT];
            pol_ac_low_r <= wdata[`PAS_MODE_POLA_BIT];
            pol_bd_low_r <= wdata[`PAS_MODE_POLB_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    assign irq_set = {(state_r == PAS_WAIT) && (state_nxt == PAS_RUN),
                      (state_r == PAS_RUN) && (state_nxt == PAS_SHUT)};
    assign irq_clr = (wr && addr == `PAS_REG_IRQ_STAT) ? wdata[1:0] : 2'b00;

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_r <= 2'b00;
        end else begin
            // Set wins over a clear in the same cycle
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_r <= 2'b00;
        end else if (wr && addr == `PAS_REG_IRQ_MASK) begin
            irq_mask_r <= wdata[1:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= `PAS_RESET_BYTE;
        end else if (rd) begin
            unique case (addr)
                `PAS_REG_SHDN: rdata_r <= {shutdown_event_flag_r, shutdown_source_select_r,
                                           pair_ac_shutdown_state_r, pair_bd_shutdown_state_r};
                `PAS_REG_PWMCON: rdata_r <= {auto_restart_enable_r, dead_band_count_r};
                `PAS_REG_MODE: rdata_r <= {5'h00, pol_bd_low_r, pol_ac_low_r, half_bridge_r};
                `PAS_REG_IRQ_STAT: rdata_r <= {6'h00, irq_stat_r};
                `PAS_REG_IRQ_MASK: rdata_r <= {6'h00, irq_mask_r};
                default: rdata_r <= `PAS_RESET_BYTE;
            endcase
        end else begin
            rdata_r <= `PAS_RESET_BYTE;
        end
    end

    assign rdata = rdata_r;
endmodule
`default_nettype wire

//--- include/pas_defines.svh
// Purpose: Constants for the PWM auto-shutdown and dead-band block.
// Assumes: One clock (instruction clock), synchronous active-high reset.
// Notes: Register offsets are register indices on the plain register port.
// How it works
// - Source field 000 disables shutdown; 111 uses pin low plus both comparators.
// - 001 comparator one high, 010 comparator two high, 011 either comparator.
// - 100 pin low; 101 adds comparator one; 110 adds comparator two.
// - Shutdown sets the status flag; with auto restart it holds while condition lasts.
// - Pair A/C state field: 01 drives both high, 1x releases both pins.
// - Pair B/D state field in bits 1-0 uses the same encoding.
// - Shutdown condition is a level; shutdown lasts while the level is present.
// - Software writes to the status flag are ignored while the condition persists.
// - After the condition clears and restart happens, output resumes at next period.
// - Automatic restart works only while the restart-enable bit is set.
// - With auto restart, hardware clears the flag once the condition goes away.
// - In half-bridge mode dead band delays only inactive-to-active edges.
// - Dead-band length equals the low seven control bits, in instruction cycles.
// - Firmware writing one to the flag acts itself as a shutdown event.
// - A source condition forces the pins at once; a firmware shutdown takes effect at the clock edge.
`ifndef PAS_DEFINES_SVH
`define PAS_DEFINES_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PAS_ADDR_W 3
`define PAS_REG_SHDN 3'h0
`define PAS_REG_PWMCON 3'h1
`define PAS_REG_MODE 3'h2
`define PAS_REG_IRQ_STAT 3'h3
`define PAS_REG_IRQ_MASK 3'h4

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PAS_SHDN_FLAG_BIT 7
`define PAS_SRC_HI 6
`define PAS_SRC_LO 4
`define PAS_AC_HI 3
`define PAS_AC_LO 2
`define PAS_BD_HI 1
`define PAS_BD_LO 0
`define PAS_RESTART_BIT 7
`define PAS_DB_HI 6
`define PAS_DB_LO 0
`define PAS_MODE_HALF_BIT 0
`define PAS_MODE_POLA_BIT 1
`define PAS_MODE_POLB_BIT 2
`define PAS_IRQ_SHDN_BIT 0
`define PAS_IRQ_RESTART_BIT 1
`define PAS_RESET_BYTE 8'h00

`endif

//--- include/pas_pkg.sv
// Purpose: Types for the PWM auto-shutdown block.
// Assumes: Imported by all design files except pas_sync and pas_bridge_model.
// Notes: Encodings of the source field and the output state sequence.
`default_nettype none
package pas_pkg;
    typedef enum logic [2:0] {
        PAS_SRC_OFF = 3'b000,
        PAS_SRC_CMP1 = 3'b001,
        PAS_SRC_CMP2 = 3'b010,
        PAS_SRC_CMPX = 3'b011,
        PAS_SRC_PIN = 3'b100,
        PAS_SRC_PIN_C1 = 3'b101,
        PAS_SRC_PIN_C2 = 3'b110,
        PAS_SRC_ALL = 3'b111
    } pas_src_type;

    typedef enum logic [1:0] {
        PAS_RUN = 2'b00,
        PAS_SHUT = 2'b01,
        PAS_WAIT = 2'b10
    } pas_state_type;
endpackage
`default_nettype wire

//--- rtl/pas_deadband.sv
// Purpose: Delays the rising edge of one active-high output by a count.
// Assumes: Count is in instruction cycles, one per clk.
// Notes: Falling edges pass at once so the opposite switch turns off fast.
`include "pas_defines.svh"
`default_nettype none
module pas_deadband
    import pas_pkg::*;
#(
    parameter int CNT_W = 7
) (
    input wire logic clk, // Instruction clock
    input wire logic rst, // Synchronous reset
    input wire logic enable, // Apply delay
    input wire logic [CNT_W-1:0] delay, // Delay count
    input wire logic raw, // Undelayed active-high level
    output logic dly // Delayed level
);
    initial begin
        if (CNT_W < 1) $error("CNT_W must be at least 1");
    end

    logic [CNT_W-1:0] cnt_r;

    // ----------------------------------------------------------------
    // Edge delay
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || !raw) begin
            cnt_r <= '0;
        end else if (cnt_r < delay) begin
            // Stops at the count; a smaller count written mid-pulse never wraps
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Inactive-to-active only; active-to-inactive is immediate
    assign dly = enable ? (raw && (cnt_r >= delay)) : raw;
endmodule
`default_nettype wire

//--- rtl/pas_sync.sv
// Purpose: Two-flop synchroniser for asynchronous level inputs.
// Assumes: Input is a slow level.
// Notes: First stage is read only by the second.
`default_nettype none
module pas_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk, // Clock
    input wire logic rst, // Synchronous reset
    input wire logic [W-1:0] d, // Asynchronous input
    output logic [W-1:0] q // Synchronised output
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= INIT;
            s2_r <= INIT;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end

    assign q = s2_r;
endmodule
`default_nettype wire

//--- sim/pas_bridge_model.sv
// Purpose: Gate drivers of the bridge as seen from pins A and B.
// Assumes: External pull-downs hold a released pin low.
// Notes: Pins C and D follow their pair fields and are left out.
`default_nettype none
module pas_bridge_model (
    input wire logic out_a, // Pin A level
    input wire logic out_a_oe, // Pin A enable
    input wire logic out_b, // Pin B level
    input wire logic out_b_oe, // Pin B enable
    output logic lvl_a, // Gate A input
    output logic lvl_b // Gate B input
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Pin resolution
    // ----------------------------------------------------------------
    // A released pin falls to the pull-down, so the switch stays off
    assign lvl_a = out_a_oe ? out_a : 1'b0;
    assign lvl_b = out_b_oe ? out_b : 1'b0;
endmodule
`default_nettype wire

//--- sim/pas_top_props.sv
// Purpose: Port-level checks of shutdown, restart and dead band.
// Assumes: Polarity bits of the mode register stay clear.
// Notes: Register fields are shadowed from bus writes.
`include "pas_defines.svh"
`default_nettype none
module pas_top_props
    import pas_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic [`PAS_ADDR_W-1:0] addr, // Index
    input wire logic [7:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic comparator_one, // Source one
    input wire logic comparator_two, // Source two
    input wire logic int_pin_n, // Pin source
    input wire logic period_start, // Period strobe
    input wire logic raw_ac, // Raw pair A/C
    input wire logic out_a, // Pin A
    input wire logic out_a_oe, // Pin A enable
    input wire logic out_b, // Pin B
    input wire logic out_c, // Pin C
    input wire logic out_c_oe, // Pin C enable
    input wire logic out_d, // Pin D
    input wire logic shutdown_active // Shutdown
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Shadow registers
    // ----------------------------------------------------------------
    logic [7:0] shdn_r;
    logic [7:0] ctl_r;
    logic half_r;
    logic [7:0] hi_cnt_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            shdn_r <= 8'h00;
            ctl_r <= 8'h00;
            half_r <= 1'b0;
        end else if (wr) begin
            if (addr == `PAS_REG_SHDN) shdn_r <= wdata;
            if (addr == `PAS_REG_PWMCON) ctl_r <= wdata;
            if (addr == `PAS_REG_MODE) half_r <= wdata[0];
        end
    end
    // Saturates so a long high phase never wraps into a false low
    always_ff @(posedge clk) begin
        if (rst || !raw_ac) hi_cnt_r <= 8'h00;
        else if (hi_cnt_r != 8'hff) hi_cnt_r <= hi_cnt_r + 8'h01;
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_cmp_one_forces: assert property (shdn_r[4] && comparator_one |-> shutdown_active)
        else $error("comparator one did not force shutdown");
    a_pin_low_forces: assert property (shdn_r[6] && !int_pin_n |-> shutdown_active)
        else $error("pin low did not force shutdown");
    a_ac_drive_high: assert property (shutdown_active && shdn_r[3:2] == 2'b01
        |-> out_a && out_c && out_a_oe && out_c_oe)
        else $error("pair A/C not driven high");
    a_ac_released: assert property (shutdown_active && shdn_r[3] |-> !out_a_oe && !out_c_oe)
        else $error("pair A/C not released");
    a_ac_drive_low: assert property (shutdown_active && shdn_r[3:2] == 2'b00
        |-> !out_a && out_a_oe)
        else $error("pair A/C not driven low");
    a_bd_drive_high: assert property (shutdown_active && shdn_r[1:0] == 2'b01
        |-> out_b && out_d)
        else $error("pair B/D not driven high");
    a_resume_at_period: assert property ($fell(shutdown_active) && !$past(rst)
        |-> $past(period_start))
        else $error("output resumed off the period boundary");
    a_hold_no_restart: assert property (shutdown_active && !ctl_r[7] && !wr && !period_start
        |=> shutdown_active)
        else $error("shutdown left without firmware clear");
    a_src_off_quiet: assert property (shdn_r[6:4] == 3'b000 && !shutdown_active && !wr
        && !$past(wr) |=> !shutdown_active)
        else $error("shutdown with sources disabled");
    a_dead_band: assert property (half_r && !shutdown_active
        |-> out_a == (raw_ac && hi_cnt_r >= {1'b0, ctl_r[6:0]}))
        else $error("dead band delay wrong");
endmodule
bind pas_top pas_top_props i_pas_top_props (.clk, .rst, .addr, .wdata, .wr, .comparator_one,
    .comparator_two, .int_pin_n, .period_start, .raw_ac, .out_a, .out_a_oe, .out_b, .out_c,
    .out_c_oe, .out_d, .shutdown_active);
`default_nettype wire

//--- sim/pas_top_test.sv
// Purpose: Register, shutdown, restart, interrupt and dead band tests.
// Assumes: Period strobe every twenty cycles, polarity bits clear.
// Notes: Exact dead band timing is checked here for counts 0 and 5, and by the checker.
`include "pas_defines.svh"
`default_nettype none
module pas_top_test
    import pas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, wr, rd, comparator_one, comparator_two, int_pin_n, hit;
    logic period_start, raw_ac, raw_bd, shutdown_active, irq, lvl_a, lvl_b;
    logic out_a, out_a_oe, out_b, out_b_oe, out_c, out_c_oe, out_d, out_d_oe;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, sc;
    logic [4:0] pcnt;
    int n_errors = 0;
    int n_checks = 0;

    pas_top i_pas_top (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .comparator_one,
        .comparator_two, .int_pin_n, .period_start, .raw_ac, .raw_bd, .out_a, .out_a_oe,
        .out_b, .out_b_oe, .out_c, .out_c_oe, .out_d, .out_d_oe, .shutdown_active, .irq);
    pas_bridge_model i_pas_bridge_model (.out_a, .out_a_oe, .out_b, .out_b_oe, .lvl_a, .lvl_b);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rst) begin
            pcnt <= 5'h00;
            period_start <= 1'b0;
        end else begin
            pcnt <= (pcnt == 5'h13) ? 5'h00 : pcnt + 5'h01;
            period_start <= (pcnt == 5'h12);
        end
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic pins(input logic [7:0] v);
        chk(out_a_oe, !v[3]);
        chk(lvl_a, v[3:2] == 2'b01);
        chk(out_b_oe, !v[1]);
        chk(out_d_oe, !v[1]);
        chk(lvl_b, v[1:0] == 2'b01);
    endtask
    // Bounded wait for the outputs to leave shutdown
    task automatic wait_idle();
        int i;
        for (i = 0; i < 60 && shutdown_active !== 1'b0; i++) cyc(1);
        if (i == 60) begin
            n_errors++;
            end_of_test();
        end
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst, wr, rd, comparator_one, comparator_two} = 5'b10000;
        {int_pin_n, raw_ac, raw_bd} = 3'b100;
        addr = 3'h0;
        wdata = 8'h00;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++) rreg(a[2:0], `PAS_RESET_BYTE);
        wreg(3'h7, 8'hff);
        rreg(3'h7, 8'h00);
        $display("register reset test done");
        wreg(`PAS_REG_PWMCON, 8'h80);
        for (int s = 0; s < 8; s++) begin
            for (int k = 0; k < 3; k++) begin
                sc = {1'b0, s[2:0], s[1:0], ~s[1:0]};
                hit = s[k];
                wreg(`PAS_REG_SHDN, sc);
                @(posedge clk);
                comparator_one <= (k == 0);
                comparator_two <= (k == 1);
                int_pin_n <= (k != 2);
                cyc(5);
                chk(shutdown_active, hit);
                if (hit) pins(sc);
                rreg(`PAS_REG_SHDN, {hit, sc[6:0]});
                @(posedge clk);
                {comparator_one, comparator_two, int_pin_n} <= 3'b001;
                wait_idle();
                rreg(`PAS_REG_SHDN, sc);
            end
        end
        chk(irq, 1'b0);
        rreg(`PAS_REG_IRQ_STAT, 8'h03);
        $display("source and auto restart test done");
        wreg(`PAS_REG_IRQ_STAT, 8'h03);
        wreg(`PAS_REG_IRQ_MASK, 8'h01);
        wreg(`PAS_REG_PWMCON, 8'h00);
        wreg(`PAS_REG_SHDN, 8'h10);
        @(posedge clk);
        comparator_one <= 1'b1;
        cyc(5);
        chk(irq, 1'b1);
        wreg(`PAS_REG_SHDN, 8'h10);
        rreg(`PAS_REG_SHDN, 8'h90);
        wreg(`PAS_REG_IRQ_STAT, 8'h01);
        cyc(1);
        chk(irq, 1'b0);
        @(posedge clk);
        comparator_one <= 1'b0;
        cyc(45);
        chk(shutdown_active, 1'b1);
        wreg(`PAS_REG_SHDN, 8'h10);
        wait_idle();
        rreg(`PAS_REG_SHDN, 8'h10);
        $display("manual restart and interrupt test done");
        wreg(`PAS_REG_SHDN, 8'h85);
        cyc(2);
        chk(shutdown_active, 1'b1);
        pins(8'h85);
        cyc(30);
        chk(shutdown_active, 1'b1);
        wreg(`PAS_REG_SHDN, 8'h05);
        wait_idle();
        $display("firmware shutdown test done");
        wreg(`PAS_REG_MODE, 8'h01);
        @(posedge clk);
        raw_bd <= 1'b1;
        cyc(8);
        for (int d = 0; d <= 5; d += 5) begin
            wreg(`PAS_REG_PWMCON, d[7:0]);
            @(posedge clk);
            raw_ac <= 1'b1;
            raw_bd <= 1'b0;
            #1;
            for (int j = 0; j <= d + 1; j++) begin
                chk(out_a, j >= d);
                chk(lvl_a & lvl_b, 1'b0);
                cyc(1);
            end
            @(posedge clk);
            raw_ac <= 1'b0;
            raw_bd <= 1'b1;
            #1;
            chk(out_a, 1'b0);
            cyc(8);
        end
        $display("dead band test done");
        end_of_test();
    end
endmodule
`default_nettype wire
